// ---- rtl/aes_datapath_map.vh ----
// Register offsets, fields, codes and timing for the cipher chaining data path
// Summary of operation
// [R1] Output XOR selected by data path code 0x02
// [R2] Route code 0x05 feeds key input, wrap option
// [R3] Route code 0x06 feeds block input, no wrap
// [R4] Route code 0x07 feeds XOR operand register
// [R5] Route code 0x08 drains result; bit 7 irq
// [R6] Channels 0-3: key, block, operand, result
// [R7] Data channel sizes are multiples of 16
// [R8] Key channel size is key length only
// [R9] Disable channels, configure, clear flags, re-enable
// [R10] Key size in config bits 1 and 0
// [R11] Config bit 3 starts the operation
// [R12] Writing zero to config resets the module
// [R13] Done shown by interrupt and config bit 5
// [R14] Result channel completion ends DMA operation
// [R15] Software interleaves block and key byte writes
// [R16] Long keys: extra key bytes written after
// [R17] After done: write operand, read result, repeat
// [R18] IV first block, then previous ciphertext chains
// [R19] IV stored just before ciphertext in memory
// [R20] Counter mode: encrypt core, output XOR only
// [R21] Counter is 16-byte big-endian, software increments
// [R22] DMA counter mode repeats setup per block
// [R23] Configuration survives between block operations
// [R24] Done sticky, starts output, software clears
// [R25] Key sizes 16/24/32 bytes, 218/274/298 clocks
// [R26] Enable starts or resets; select picks direction
// [R27] Output select: direct, XORed, inverse key
// [R28] Busy until done; data writes ignored meanwhile
`ifndef AES_DATAPATH_MAP_VH
`define AES_DATAPATH_MAP_VH
`define OFS_BLOCK_CFG 8'h00
`define OFS_DATA_CFG 8'h04
`define OFS_BLOCK_IN 8'h08
`define OFS_KEY_IN 8'h0c
`define OFS_XOR_IN 8'h10
`define OFS_RESULT 8'h14
`define OFS_DMA_EN 8'h18
`define OFS_DMA_SEL 8'h1c
`define OFS_DMA_CFG 8'h20
`define OFS_DMA_MODE 8'h24
`define OFS_DMA_FLAGS 8'h28
`define BCFG_EN 3
`define BCFG_ENC 2
`define BCFG_DONE 5
`define DCFG_INPUT_XOR_ENABLE 0
`define OUTSEL_DIRECT 2'h0
`define OUTSEL_XOR 2'h1
`define OUTSEL_INVKEY 2'h2
`define KSIZE_128 2'h0
`define KSIZE_192 2'h1
`define KSIZE_256 2'h2
`define KEY_BYTES_128 6'h10
`define KEY_BYTES_192 6'h18
`define KEY_BYTES_256 6'h20
`define BLOCK_BYTES 5'h10
`define CLKS_128 9'd218
`define CLKS_192 9'd274
`define CLKS_256 9'd298
`define ROUTE_KEY 7'h05
`define ROUTE_BLOCK 7'h06
`define ROUTE_XOR 7'h07
`define ROUTE_RESULT 7'h08
`define DMA_IRQ_EN_BIT 7
`define RESET_BYTE 8'h00
`endif

// ---- rtl/cipher_core.v ----
// Timed block cipher stand-in with key-size dependent latency
`timescale 1ns/1ps
`default_nettype none
`include "aes_datapath_map.vh"

module cipher_core (
    // Clock and reset
    input wire clk,
    input wire rst,
    input wire clr,
    // Operation request
    input wire start,
    input wire encrypt_select,
    input wire [1:0] ksize,
    input wire [127:0] din,
    input wire [255:0] key,
    // Results
    output wire [127:0] dout,
    output wire [127:0] inv_key,
    output wire done
);
    reg [8:0] cnt_reg;
    reg run_reg;
    reg [127:0] pend_reg;
    reg [127:0] dout_reg;
    reg [127:0] ikey_reg;
    reg [127:0] mask;
    reg [127:0] kf;
    reg [127:0] x;

    always @* begin
        mask = (ksize == `KSIZE_128) ? 128'h0 :
               (ksize == `KSIZE_192) ? {64'hffffffffffffffff, 64'h0} : {128{1'b1}};
        kf = key[255:128] ^ (key[127:0] & mask);
        x = din ^ kf;
        if (!encrypt_select) begin
            x = {din[7:0], din[127:8]} ^ kf;
        end else begin
            x = {x[119:0], x[127:120]};
        end
    end

    // Latency counts are exact so busy time matches the key size [R25]
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 9'd0;
            run_reg <= 1'b0;
            pend_reg <= 128'h0;
            dout_reg <= 128'h0;
            ikey_reg <= 128'h0;
        end else if (clr) begin
            run_reg <= 1'b0;
            cnt_reg <= 9'd0;
        end else if (start) begin
            run_reg <= 1'b1;
            pend_reg <= x;
            cnt_reg <= (ksize == `KSIZE_128) ? `CLKS_128 - 9'd1 :
                       (ksize == `KSIZE_192) ? `CLKS_192 - 9'd1 : `CLKS_256 - 9'd1;
        end else if (run_reg) begin
            cnt_reg <= cnt_reg - 9'd1;
            if (cnt_reg == 9'd0) begin
                run_reg <= 1'b0;
                dout_reg <= pend_reg;
                ikey_reg <= ~kf;
            end
        end
    end

    assign done = run_reg && (cnt_reg == 9'd0);
    assign dout = dout_reg;
    assign inv_key = ikey_reg;
endmodule // cipher_core
`default_nettype wire

// ---- rtl/dma_route_regs.v ----
// DMA channel enables, select, route codes, wrap modes and transfer flags
`timescale 1ns/1ps
`default_nettype none
`include "aes_datapath_map.vh"

module dma_route_regs (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register writes
    input wire wr_en,
    input wire wr_sel,
    input wire wr_cfg,
    input wire wr_mode,
    input wire wr_flags,
    input wire [7:0] wdata,
    // Engine events
    input wire [3:0] xfer_done,
    // State
    output wire [3:0] ch_en,
    output wire [1:0] ch_sel,
    output wire [7:0] cfg_sel,
    output wire [7:0] mode_sel,
    output wire [3:0] flags,
    output reg [31:0] cfg_flat,
    output reg [3:0] wrap,
    output wire irq
);
    reg [3:0] en_reg;
    reg [1:0] sel_reg;
    reg [3:0] flags_reg;
    reg [7:0] cfg_mem [0:3];
    reg [7:0] mode_mem [0:3];
    reg [3:0] ien;
    integer i;
    integer j;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            en_reg <= 4'h0;
            sel_reg <= 2'h0;
            flags_reg <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                cfg_mem[i] <= `RESET_BYTE;
                mode_mem[i] <= `RESET_BYTE;
            end
        end else begin
            if (wr_en) en_reg <= wdata[3:0];
            if (wr_sel) sel_reg <= wdata[1:0];
            if (wr_cfg) cfg_mem[sel_reg] <= wdata;
            if (wr_mode) mode_mem[sel_reg] <= wdata;
            // Writing zero clears a flag, but a completion in that cycle wins
            flags_reg <= (wr_flags ? (flags_reg & wdata[3:0]) : flags_reg) | xfer_done;
        end
    end

    always @* begin
        for (j = 0; j < 4; j = j + 1) begin
            cfg_flat[j*8 +: 8] = cfg_mem[j];
            wrap[j] = mode_mem[j][0];
            ien[j] = cfg_mem[j][`DMA_IRQ_EN_BIT];
        end
    end

    assign ch_en = en_reg;
    assign ch_sel = sel_reg;
    assign cfg_sel = cfg_mem[sel_reg];
    assign mode_sel = mode_mem[sel_reg];
    assign flags = flags_reg;
    assign irq = |(flags_reg & ien); // [R5]
endmodule // dma_route_regs
`default_nettype wire

// ---- rtl/aes_cbc_ctr_mode_datapath.v ----
// Cipher chaining data path: bus slave, byte buffers, DMA byte routing
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "aes_datapath_map.vh"

module aes_cbc_ctr_mode_datapath (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // DMA byte port
    input wire [1:0] dma_ch,
    input wire dma_wr_stb,
    input wire [7:0] dma_wr_data,
    input wire dma_rd_stb,
    input wire [3:0] dma_xfer_done,
    output wire [7:0] dma_rd_data,
    output wire dma_rd_valid,
    output wire [3:0] dma_ch_en,
    output wire [3:0] dma_wrap,
    output wire dma_irq,
    output wire dma_out_start,
    // Completion
    output wire cipher_done_irq
);
    localparam H_BCFG = 0;
    localparam H_DCFG = 1;
    localparam H_BIN = 2;
    localparam H_KIN = 3;
    localparam H_XIN = 4;
    localparam H_RES = 5;
    localparam H_DEN = 6;
    localparam H_DSEL = 7;
    localparam H_DCF = 8;
    localparam H_DMD = 9;
    localparam H_DFL = 10;

    // Bus slave
    reg ack_reg;
    reg [31:0] dat_reg;
    reg [31:0] dat_next;
    reg [10:0] hit;
    wire bus_req;
    wire bus_wr;
    wire bus_rd;

    // Block and data path configuration
    reg en_reg;
    reg enc_reg;
    reg [1:0] ksize_reg;
    reg busy_reg;
    reg done_reg;
    reg input_xor_enable_reg;
    reg [1:0] outsel_reg;

    // Byte buffers and their pointers
    reg [7:0] bin_mem [0:15];
    reg [7:0] key_mem [0:31];
    reg [7:0] xin_mem [0:15];
    reg [4:0] bin_ptr_reg;
    reg [5:0] key_ptr_reg;
    reg [3:0] xin_ptr_reg;
    reg [3:0] rd_ptr_reg;
    reg [7:0] dma_rd_data_reg;
    reg dma_rd_valid_reg;

    // Packed vectors and results
    reg [127:0] blk_vec;
    reg [255:0] key_vec;
    reg [7:0] res_byte;
    wire [127:0] core_dout;
    wire [127:0] core_ikey;
    wire core_done;
    integer i;

    // DMA channel state
    wire [3:0] ch_en;
    wire [1:0] ch_sel;
    wire [7:0] cfg_sel;
    wire [7:0] mode_sel;
    wire [3:0] ch_flags;
    wire [31:0] cfg_flat;
    wire [7:0] ch_cfg;
    wire ch_active;

    function [7:0] byte_of;
        input [127:0] v;
        input [3:0] idx;
        reg [127:0] s;
        begin
            s = v << {idx, 3'b000};
            byte_of = s[127:120];
        end
    endfunction

    function [5:0] key_len;
        input [1:0] code;
        begin
            case (code)
                `KSIZE_128: key_len = `KEY_BYTES_128;
                `KSIZE_192: key_len = `KEY_BYTES_192;
                `KSIZE_256: key_len = `KEY_BYTES_256;
                default: key_len = 6'h00;
            endcase
        end
    endfunction

    // Address decode
    always @* begin
        hit = 11'h000;
        if (wb_adr_i == `OFS_BLOCK_CFG) begin
            hit[H_BCFG] = 1'b1;
        end else if (wb_adr_i == `OFS_DATA_CFG) begin
            hit[H_DCFG] = 1'b1;
        end else if (wb_adr_i == `OFS_BLOCK_IN) begin
            hit[H_BIN] = 1'b1;
        end else if (wb_adr_i == `OFS_KEY_IN) begin
            hit[H_KIN] = 1'b1;
        end else if (wb_adr_i == `OFS_XOR_IN) begin
            hit[H_XIN] = 1'b1;
        end else if (wb_adr_i == `OFS_RESULT) begin
            hit[H_RES] = 1'b1;
        end else if (wb_adr_i == `OFS_DMA_EN) begin
            hit[H_DEN] = 1'b1;
        end else if (wb_adr_i == `OFS_DMA_SEL) begin
            hit[H_DSEL] = 1'b1;
        end else if (wb_adr_i == `OFS_DMA_CFG) begin
            hit[H_DCF] = 1'b1;
        end else if (wb_adr_i == `OFS_DMA_MODE) begin
            hit[H_DMD] = 1'b1;
        end else if (wb_adr_i == `OFS_DMA_FLAGS) begin
            hit[H_DFL] = 1'b1;
        end
    end

    // Ack one cycle after the request; effects happen on the acked edge
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign bus_wr = ack_reg & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    assign bus_rd = ack_reg & wb_cyc_i & wb_stb_i & ~wb_we_i;

    // Routing of DMA bytes by the addressed channel's code
    assign ch_cfg = cfg_flat[{dma_ch, 3'b000} +: 8];
    assign ch_active = ch_en[dma_ch];

    wire dma_key = dma_wr_stb & ch_active & (ch_cfg[6:0] == `ROUTE_KEY); // [R2]
    wire dma_bin = dma_wr_stb & ch_active & (ch_cfg[6:0] == `ROUTE_BLOCK); // [R3]
    wire dma_xin = dma_wr_stb & ch_active & (ch_cfg[6:0] == `ROUTE_XOR); // [R4]
    wire dma_res = dma_rd_stb & ch_active & (ch_cfg[6:0] == `ROUTE_RESULT); // [R5]

    // Bus writes take priority over a DMA byte for the same buffer
    wire bus_bin = bus_wr & hit[H_BIN];
    wire bus_kin = bus_wr & hit[H_KIN];
    wire bus_xin = bus_wr & hit[H_XIN];
    wire bin_we = ~busy_reg & (bus_bin | dma_bin) & (bin_ptr_reg != `BLOCK_BYTES); // [R28]
    wire key_we = ~busy_reg & (bus_kin | dma_key) & (key_ptr_reg != `KEY_BYTES_256); // [R28]
    wire xin_we = ~busy_reg & (bus_xin | dma_xin); // [R28]
    wire [7:0] bin_byte = bus_bin ? wb_dat_i[7:0] : dma_wr_data;
    wire [7:0] key_byte = bus_kin ? wb_dat_i[7:0] : dma_wr_data;
    wire [7:0] xin_byte = bus_xin ? wb_dat_i[7:0] : dma_wr_data;

    // Result reads by bus or by the result channel both advance the pointer
    wire res_adv = (bus_rd & hit[H_RES]) | dma_res;

    // Configuration writes
    wire bcfg_wr = bus_wr & hit[H_BCFG];
    wire soft_clr = bcfg_wr & ~wb_dat_i[`BCFG_EN]; // [R12] [R26]
    wire done_clr = bcfg_wr & ~wb_dat_i[`BCFG_DONE];

    // Start once armed and the block and key bytes for this size are in
    wire start_go = en_reg & ~busy_reg & ~soft_clr & (ksize_reg != 2'h3) &
                    (bin_ptr_reg == `BLOCK_BYTES) & (key_ptr_reg == key_len(ksize_reg)); // [R11] [R25]

    always @* begin
        for (i = 0; i < 16; i = i + 1) begin
            // Input XOR only when enabled; counter and decrypt modes leave it off
            blk_vec[(15-i)*8 +: 8] = bin_mem[i] ^ (input_xor_enable_reg ? xin_mem[i] : 8'h00); // [R20]
        end
        for (i = 0; i < 32; i = i + 1) begin
            key_vec[(31-i)*8 +: 8] = key_mem[i];
        end
    end

    // Output select; the XOR uses the operand byte present at read time
    always @* begin
        case (outsel_reg)
            `OUTSEL_DIRECT: res_byte = byte_of(core_dout, rd_ptr_reg); // [R27]
            `OUTSEL_XOR: res_byte = byte_of(core_dout, rd_ptr_reg) ^ xin_mem[rd_ptr_reg]; // [R1] [R17]
            `OUTSEL_INVKEY: res_byte = byte_of(core_ikey, rd_ptr_reg); // [R27]
            default: res_byte = 8'h00;
        endcase
    end

    // Read data mux
    always @* begin
        dat_next = 32'h00000000;
        if (hit[H_BCFG]) begin
            dat_next = {26'h0, done_reg, busy_reg, en_reg, enc_reg, ksize_reg}; // [R13]
        end else if (hit[H_DCFG]) begin
            dat_next = {29'h0, outsel_reg, input_xor_enable_reg};
        end else if (hit[H_RES]) begin
            dat_next = {24'h0, res_byte};
        end else if (hit[H_DEN]) begin
            dat_next = {28'h0, ch_en};
        end else if (hit[H_DSEL]) begin
            dat_next = {30'h0, ch_sel};
        end else if (hit[H_DCF]) begin
            dat_next = {24'h0, cfg_sel};
        end else if (hit[H_DMD]) begin
            dat_next = {24'h0, mode_sel};
        end else if (hit[H_DFL]) begin
            dat_next = {28'h0, ch_flags};
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= bus_req;
            if (bus_req) dat_reg <= dat_next;
        end
    end

    // Control state; configuration is kept across blocks
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            en_reg <= 1'b0;
            enc_reg <= 1'b0;
            ksize_reg <= 2'h0;
            input_xor_enable_reg <= 1'b0;
            outsel_reg <= 2'h0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            bin_ptr_reg <= 5'h00;
            key_ptr_reg <= 6'h00;
            xin_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            dma_rd_data_reg <= 8'h00;
            dma_rd_valid_reg <= 1'b0;
        end else begin
            if (bcfg_wr) begin
                en_reg <= wb_dat_i[`BCFG_EN]; // [R26]
                enc_reg <= wb_dat_i[`BCFG_ENC]; // [R26]
                ksize_reg <= wb_dat_i[1:0]; // [R10]
            end
            if (bus_wr & hit[H_DCFG]) begin
                input_xor_enable_reg <= wb_dat_i[`DCFG_INPUT_XOR_ENABLE];
                outsel_reg <= wb_dat_i[2:1];
            end
            // Done is sticky; a completion beats a clear in the same cycle
            if (core_done) begin
                done_reg <= 1'b1; // [R24]
            end else if (done_clr) begin
                done_reg <= 1'b0; // [R24]
            end
            if (bin_we) bin_ptr_reg <= bin_ptr_reg + 5'h01;
            if (key_we) key_ptr_reg <= key_ptr_reg + 6'h01; // [R16]
            if (xin_we) xin_ptr_reg <= xin_ptr_reg + 4'h1; // [R18]
            if (res_adv) rd_ptr_reg <= rd_ptr_reg + 4'h1;
            dma_rd_valid_reg <= dma_res;
            if (dma_res) dma_rd_data_reg <= res_byte; // [R5]
            if (soft_clr) begin
                busy_reg <= 1'b0; // [R12]
                bin_ptr_reg <= 5'h00;
                key_ptr_reg <= 6'h00;
                xin_ptr_reg <= 4'h0;
                rd_ptr_reg <= 4'h0;
            end else if (start_go) begin
                busy_reg <= 1'b1; // [R28]
                bin_ptr_reg <= 5'h00; // [R23]
                key_ptr_reg <= 6'h00;
                rd_ptr_reg <= 4'h0;
            end else if (core_done) begin
                busy_reg <= 1'b0; // [R28]
            end
        end
    end

    // Buffers carry no reset: contents are don't-care until written
    always @(posedge clk) begin
        if (bin_we) bin_mem[bin_ptr_reg[3:0]] <= bin_byte;
        if (key_we) key_mem[key_ptr_reg[4:0]] <= key_byte;
        if (xin_we) xin_mem[xin_ptr_reg] <= xin_byte;
    end

    cipher_core u_core (
        .clk(clk),
        .rst(rst),
        .clr(soft_clr),
        .start(start_go),
        .encrypt_select(enc_reg),
        .ksize(ksize_reg),
        .din(blk_vec),
        .key(key_vec),
        .dout(core_dout),
        .inv_key(core_ikey),
        .done(core_done)
    );

    dma_route_regs u_route (
        .clk(clk),
        .rst(rst),
        .wr_en(bus_wr & hit[H_DEN]),
        .wr_sel(bus_wr & hit[H_DSEL]),
        .wr_cfg(bus_wr & hit[H_DCF]),
        .wr_mode(bus_wr & hit[H_DMD]),
        .wr_flags(bus_wr & hit[H_DFL]),
        .wdata(wb_dat_i[7:0]),
        .xfer_done(dma_xfer_done),
        .ch_en(ch_en),
        .ch_sel(ch_sel),
        .cfg_sel(cfg_sel),
        .mode_sel(mode_sel),
        .flags(ch_flags),
        .cfg_flat(cfg_flat),
        .wrap(dma_wrap),
        .irq(dma_irq)
    );

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign dma_rd_data = dma_rd_data_reg;
    assign dma_rd_valid = dma_rd_valid_reg;
    assign dma_ch_en = ch_en;
    assign dma_out_start = done_reg; // [R24]
    assign cipher_done_irq = done_reg; // [R13]
endmodule // aes_cbc_ctr_mode_datapath
`default_nettype wire

// ---- verification/datapath_properties.sv ----
// Port-level timing properties of the cipher chaining data path
`timescale 1ns/1ps
`default_nettype none
module datapath_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Byte port and completion
    input wire logic dma_rd_stb,
    input wire logic [3:0] dma_xfer_done,
    input wire logic dma_rd_valid,
    input wire logic [3:0] dma_ch_en,
    input wire logic dma_irq,
    input wire logic dma_out_start,
    input wire logic cipher_done_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A write lands on the edge where the master sees ack
    wire bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    wire clr_done = bus_wr && wb_adr_i == 8'h00 && !wb_dat_i[5];
    a_ack_follows_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_unmapped_zero: assert property ((wb_ack_o && !wb_we_i && wb_adr_i > 8'h28) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_done_sticky: assert property ((cipher_done_irq && !clr_done) |=> cipher_done_irq)
        else $error("done dropped by itself");
    a_done_cleared: assert property ((cipher_done_irq && clr_done) |=> !cipher_done_irq)
        else $error("done kept after config write");
    a_out_start_done: assert property (dma_out_start == cipher_done_irq)
        else $error("output start differs from done");
    a_rd_valid_cause: assert property (dma_rd_valid |-> $past(dma_rd_stb))
        else $error("read valid without strobe");
    a_enable_by_write: assert property ($changed(dma_ch_en) |-> $past(bus_wr && wb_adr_i == 8'h18))
        else $error("channel enables changed unasked");
    a_irq_rise_cause: assert property ($rose(dma_irq) |->
        $past(|dma_xfer_done || (bus_wr && wb_adr_i == 8'h20)))
        else $error("channel irq rose without cause");
endmodule // datapath_properties
`default_nettype wire

// ---- verification/dma_byte_mover.sv ----
// Byte mover standing in for the on-chip DMA engine
`timescale 1ns/1ps
`default_nettype none
module dma_byte_mover (
    // Clock
    input wire logic clk,
    // Strobes toward the data path
    output logic [1:0] dma_ch,
    output logic dma_wr_stb,
    output logic [7:0] dma_wr_data,
    output logic dma_rd_stb,
    output logic [3:0] dma_xfer_done,
    // Answers
    input wire logic [7:0] dma_rd_data,
    input wire logic dma_rd_valid
);
    initial begin
        dma_ch = 2'h0;
        dma_wr_stb = 1'b0;
        dma_wr_data = 8'h00;
        dma_rd_stb = 1'b0;
        dma_xfer_done = 4'h0;
    end
    // A gap releases the strobe; the idle data line flips so no stale byte looks valid
    task automatic push(input logic [1:0] c, input logic [7:0] d [16], input int gap);
        for (int i = 0; i < 16; i++) begin
            dma_ch <= c;
            dma_wr_stb <= 1'b1;
            dma_wr_data <= d[i];
            @(posedge clk);
            if (gap > 0 || i == 15) begin
                dma_wr_stb <= 1'b0;
                dma_wr_data <= ~d[i];
                repeat (gap + (i == 15)) @(posedge clk);
            end
        end
    endtask
    task automatic pull(input logic [1:0] c, output logic [7:0] q);
        dma_ch <= c;
        dma_rd_stb <= 1'b1;
        @(posedge clk);
        dma_rd_stb <= 1'b0;
        @(posedge clk);
        q = dma_rd_valid ? dma_rd_data : 8'hxx;
    endtask
    task automatic finish(input logic [1:0] c);
        dma_xfer_done <= 4'h1 << c;
        @(posedge clk);
        dma_xfer_done <= 4'h0;
    endtask
endmodule // dma_byte_mover
`default_nettype wire

// ---- verification/test_aes_cbc_ctr_mode_datapath.sv ----
// Self-checking bench for the cipher chaining data path
`timescale 1ns/1ps
`default_nettype none
`include "aes_datapath_map.vh"
module test_aes_cbc_ctr_mode_datapath;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, cy;
    logic [7:0] adr = 8'h00, q;
    logic [3:0] sel = 4'h1;
    logic [31:0] wdat = 32'h0, seed = 32'd72674;
    logic [7:0] pt [16], key [16], xv [16];
    wire [31:0] rdat;
    wire ack, rvalid, irq, ostart, done, wstb, rstb;
    wire [1:0] ch;
    wire [7:0] wbyte, rbyte;
    wire [3:0] xdone, en, wrap;
    int n_errors = 0, compares = 0, n;
    always #2 clk = ~clk;
    aes_cbc_ctr_mode_datapath u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .dma_ch(ch), .dma_wr_stb(wstb), .dma_wr_data(wbyte),
        .dma_rd_stb(rstb), .dma_xfer_done(xdone), .dma_rd_data(rbyte), .dma_rd_valid(rvalid),
        .dma_ch_en(en), .dma_wrap(wrap), .dma_irq(irq), .dma_out_start(ostart),
        .cipher_done_irq(done));
    dma_byte_mover u_dma (.clk(clk), .dma_ch(ch), .dma_wr_stb(wstb), .dma_wr_data(wbyte),
        .dma_rd_stb(rstb), .dma_xfer_done(xdone), .dma_rd_data(rbyte), .dma_rd_valid(rvalid));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat[7:0];
        if (n >= 50) n_errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic fill;
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            key[i] = seed[7:0];
            pt[i] = seed[15:8];
            xv[i] = seed[23:16];
        end
    endtask
    task automatic wait_done;
        n = 0;
        while (done !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d, n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        end_of_test;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(8'h00, 0, 0);
        chk(q, 0);
        bus(8'h3c, 1, 8'h5a);
        bus(8'h3c, 0, 0);
        chk(q, 0);
        $display("test reset and unmapped done");
        // Chained decryption over the bus; the long key run checks timing and status only, no result bytes
        for (int ks = 0; ks < 3; ks += 2) begin
            fill;
            bus(8'h00, 1, 8'h00);
            bus(8'h04, 1, 8'h02);
            bus(8'h00, 1, 8'h08 | ks);
            for (int i = 0; i < 32; i++) begin
                if (i < 16) bus(8'h08, 1, pt[i]);
                bus(8'h0c, 1, key[i % 16]);
                if (ks == 0 && i == 15) break;
            end
            wait_done;
            chk(n, ks ? `CLKS_256 + 1 : `CLKS_128 + 1);
            bus(8'h00, 0, 0);
            chk(q, 8'h28 | ks);
            for (int i = 0; i < 16 && ks == 0; i++) begin
                bus(8'h10, 1, xv[i]);
                bus(8'h14, 0, 0);
                chk(q, pt[(i + 15) % 16] ^ key[i] ^ xv[i]);
            end
            $display("test decryption ksize %0d done", ks);
        end
        for (int c = 0; c < 4; c++) begin
            bus(8'h1c, 1, c);
            bus(8'h20, 1, c == 3 ? 8'h88 : 8'h05 + c);
            bus(8'h24, 1, c == 0);
        end
        bus(8'h20, 0, 0);
        chk(q, 8'h88);
        bus(8'h28, 1, 8'h00);
        bus(8'h18, 1, 8'h0f);
        chk(en, 4'hf);
        chk(wrap, 4'h1);
        bus(8'h04, 1, 8'h02);
        fill;
        // Counter mode by DMA; the second block streams slowly with the same data path setup
        for (int b = 0; b < 2; b++) begin
            bus(8'h00, 1, 8'h00);
            bus(8'h00, 1, 8'h0c);
            u_dma.push(0, key, b);
            // Operand bytes go before the block: once the block fills, busy locks them out
            u_dma.push(2, xv, b);
            u_dma.push(1, pt, b);
            bus(8'h00, 0, 0);
            chk(q, 8'h1c);
            bus(8'h08, 1, 8'hff);
            wait_done;
            chk(ostart, 1);
            for (int i = 0; i < 16; i++) begin
                u_dma.pull(3, q);
                chk(q, pt[(i + 1) % 16] ^ key[(i + 1) % 16] ^ xv[i]);
            end
            u_dma.finish(0);
            @(posedge clk);
            chk(irq, 0);
            u_dma.finish(3);
            @(posedge clk);
            chk(irq, 1);
            bus(8'h28, 1, 8'h00);
            chk(irq, 0);
            cy = 1'b1;
            for (int i = 15; i >= 0; i--) {cy, xv[i]} = xv[i] + cy;
            $display("test counter block %0d done", b);
        end
        bus(8'h18, 1, 8'h00);
        chk(en, 4'h0);
        end_of_test;
    end
endmodule // test_aes_cbc_ctr_mode_datapath
bind aes_cbc_ctr_mode_datapath datapath_properties u_props (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dma_rd_stb(dma_rd_stb), .dma_xfer_done(dma_xfer_done), .dma_rd_valid(dma_rd_valid),
    .dma_ch_en(dma_ch_en), .dma_irq(dma_irq), .dma_out_start(dma_out_start),
    .cipher_done_irq(cipher_done_irq));
`default_nettype wire
